// ===== csm_consts.svh
// What this block does
// R01 - Digital source: terminal picks direction
// R02 - Serial source: bus bit picks direction
// R03 - AND source: reverse only when both set
// R04 - OR source: reverse when either set
// R05 - Single source setup code selects setup 1-4
// R06 - AND source: setup from bitwise AND
// R07 - OR source: setup from bitwise OR
// R08 - Bus preset references only in native profile
// R09 - Profidrive profile allows two bus jog speeds
// R10 - Bus jog speeds limited 0 to max frequency
// R11 - Profile selector: 0 Profidrive, 1 native, default 1
// R12 - Telegram interval limit 1-99 s, default 1
// R13 - Interval exceeded means communication lost, react
// R14 - Reaction codes 0-5; 1-5 drop relay
// R15 - Timer restarts per telegram, one-second tick
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
`define CSM_ADDR_CTRL      8'h00
`define CSM_ADDR_TIMEOUT   8'h04
`define CSM_ADDR_JOG1      8'h08
`define CSM_ADDR_JOG2      8'h0C
`define CSM_ADDR_FMAX      8'h10
`define CSM_ADDR_STATUS    8'h14
`define CSM_ADDR_IRQ_STAT  8'h18
`define CSM_ADDR_IRQ_MASK  8'h1C
`define CSM_CTRL_DIR_LSB   0
`define CSM_CTRL_SETUP_LSB 2
`define CSM_CTRL_PRES_LSB  4
`define CSM_CTRL_PROF_BIT  6
`define CSM_CTRL_REACT_LSB 8
`define CSM_CTRL_RESET     32'h0000_00FF
`define CSM_TIMEOUT_RESET  7'h01
`define CSM_TIMEOUT_MIN    7'h01
`define CSM_TIMEOUT_MAX    7'h63
`define CSM_REACT_MAX      3'h5
`define CSM_CLK_HZ         20000000
`define CSM_TICK_SEC       1
`define CSM_RESP_OKAY      2'h0
`define CSM_RESP_SLVERR    2'h2
`endif

// ===== csm_pkg.sv
package csm_pkg;
	typedef enum logic [1:0] {
		CSM_SRC_DIGITAL = 2'h0,
		CSM_SRC_SERIAL  = 2'h1,
		CSM_SRC_AND     = 2'h2,
		CSM_SRC_OR      = 2'h3
	} csm_src_t;
	typedef enum logic [1:0] {
		CSM_WS_IDLE = 2'b01,
		CSM_WS_RESP = 2'b10
	} csm_wstate_t;
endpackage

// ===== csm_merge.sv
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "csm_consts.svh"
module csm_merge #(
	parameter int TICK_CYCLES = `CSM_CLK_HZ * `CSM_TICK_SEC,
	parameter int FREQ_W      = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              term_reverse,
	input  wire logic [1:0]        term_setup,
	input  wire logic [1:0]        term_preset,
	input  wire logic              bus_reverse,
	input  wire logic [1:0]        bus_setup,
	input  wire logic [1:0]        bus_preset,
	input  wire logic              bus_jog1_req,
	input  wire logic              bus_jog2_req,
	input  wire logic              telegram_ok,
	output logic                   dir_ccw,
	output logic [1:0]             active_setup,
	output logic [1:0]             preset_sel,
	output logic                   jog_active,
	output logic [FREQ_W-1:0]      jog_freq,
	output logic                   comm_lost,
	output logic [2:0]             timeout_reaction,
	output logic                   relay_on,
	output logic                   irq
);
	logic [31:0]       ctrl_reg;
	logic [6:0]        timeout_reg;
	logic [FREQ_W-1:0] jog1_reg;
	logic [FREQ_W-1:0] jog2_reg;
	logic [FREQ_W-1:0] fmax_reg;
	logic [1:0]        irq_stat_reg;
	logic [1:0]        irq_mask_reg;
	logic [24:0]       tick_cnt_reg;
	logic              tick;
	logic [6:0]        sec_cnt_reg;
	logic              lost_event;
	logic              restore_event;
	csm_pkg::csm_wstate_t wstate_reg;
	logic              aw_have_reg;
	logic              w_have_reg;
	logic [7:0]        awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_fire;
	logic [31:0]       wmask;
	logic [31:0]       ctrl_next;
	logic [31:0]       rd_next;
	logic              rd_err;

	csm_pkg::csm_src_t dir_src;
	csm_pkg::csm_src_t setup_src;
	csm_pkg::csm_src_t pres_src;
	logic              native_prof;
	assign dir_src     = csm_pkg::csm_src_t'(ctrl_reg[`CSM_CTRL_DIR_LSB +: 2]);
	assign setup_src   = csm_pkg::csm_src_t'(ctrl_reg[`CSM_CTRL_SETUP_LSB +: 2]);
	assign pres_src    = csm_pkg::csm_src_t'(ctrl_reg[`CSM_CTRL_PRES_LSB +: 2]);
	assign native_prof = ctrl_reg[`CSM_CTRL_PROF_BIT];

	// Write channel: address and data are captured in either order
	assign wr_fire = (wstate_reg == csm_pkg::CSM_WS_IDLE) && aw_have_reg && w_have_reg;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
		end
		ctrl_next = (ctrl_reg & ~wmask) | (wdata_reg & wmask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_reg    <= csm_pkg::CSM_WS_IDLE;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CSM_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			case (wstate_reg)
			csm_pkg::CSM_WS_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
				end else if (!aw_have_reg && s_axi_awvalid) begin
					s_axi_awready <= 1'b1;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata;
					wstrb_reg  <= s_axi_wstrb;
				end else if (!w_have_reg && s_axi_wvalid) begin
					s_axi_wready <= 1'b1;
				end
				if (wr_fire) begin
					aw_have_reg  <= 1'b0;
					w_have_reg   <= 1'b0;
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= (awaddr_reg > `CSM_ADDR_IRQ_MASK || awaddr_reg[1:0] != 2'h0
						|| awaddr_reg == `CSM_ADDR_STATUS) ? `CSM_RESP_SLVERR : `CSM_RESP_OKAY;
					wstate_reg   <= csm_pkg::CSM_WS_RESP;
				end
			end
			csm_pkg::CSM_WS_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
					wstate_reg   <= csm_pkg::CSM_WS_IDLE;
				end
			end
			default: wstate_reg <= csm_pkg::CSM_WS_IDLE;
			endcase
		end
	end

	// Configuration registers; out-of-range writes are refused and leave the register unchanged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg     <= `CSM_CTRL_RESET; // R11
			timeout_reg  <= `CSM_TIMEOUT_RESET; // R12
			jog1_reg     <= '0;
			jog2_reg     <= '0;
			fmax_reg     <= '1;
			irq_mask_reg <= 2'h0;
		end else if (wr_fire) begin
			case (awaddr_reg)
			`CSM_ADDR_CTRL: begin
				if (ctrl_next[`CSM_CTRL_REACT_LSB +: 3] <= `CSM_REACT_MAX) begin // R14
					ctrl_reg <= ctrl_next & 32'h0000_077F;
				end
			end
			`CSM_ADDR_TIMEOUT: begin
				if (wstrb_reg[0] && wdata_reg[6:0] >= `CSM_TIMEOUT_MIN
					&& wdata_reg[6:0] <= `CSM_TIMEOUT_MAX && wdata_reg[7] == 1'b0) begin // R12
					timeout_reg <= wdata_reg[6:0];
				end
			end
			`CSM_ADDR_JOG1: begin
				if (wdata_reg[FREQ_W-1:0] <= fmax_reg) begin // R10
					jog1_reg <= wdata_reg[FREQ_W-1:0];
				end
			end
			`CSM_ADDR_JOG2: begin
				if (wdata_reg[FREQ_W-1:0] <= fmax_reg) begin // R10
					jog2_reg <= wdata_reg[FREQ_W-1:0];
				end
			end
			`CSM_ADDR_FMAX:     fmax_reg <= wdata_reg[FREQ_W-1:0];
			`CSM_ADDR_IRQ_MASK: irq_mask_reg <= wdata_reg[1:0];
			default: ;
			endcase
		end
	end

	// One-second tick and telegram interval watchdog
	assign tick = (tick_cnt_reg == 25'(TICK_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || telegram_ok) begin
			tick_cnt_reg <= '0; // R15
		end else if (tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 25'h000_0001;
		end
	end

	assign lost_event    = !comm_lost && tick && (sec_cnt_reg + 7'h01 >= timeout_reg) && !telegram_ok;
	assign restore_event = comm_lost && telegram_ok;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_cnt_reg <= 7'h00;
			comm_lost   <= 1'b0;
		end else if (telegram_ok) begin
			sec_cnt_reg <= 7'h00; // R15
			comm_lost   <= 1'b0;
		end else if (lost_event) begin
			comm_lost   <= 1'b1; // R13
		end else if (tick && !comm_lost) begin
			sec_cnt_reg <= sec_cnt_reg + 7'h01; // R15
		end
	end

	// Merged command outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_ccw          <= 1'b0;
			active_setup     <= 2'h0;
			preset_sel       <= 2'h0;
			jog_active       <= 1'b0;
			jog_freq         <= '0;
			timeout_reaction <= 3'h0;
			relay_on         <= 1'b1;
		end else begin
			case (dir_src)
			csm_pkg::CSM_SRC_DIGITAL: dir_ccw <= term_reverse; // R01
			csm_pkg::CSM_SRC_SERIAL:  dir_ccw <= bus_reverse; // R02
			csm_pkg::CSM_SRC_AND:     dir_ccw <= term_reverse & bus_reverse; // R03
			csm_pkg::CSM_SRC_OR:      dir_ccw <= term_reverse | bus_reverse; // R04
			default:                  dir_ccw <= term_reverse;
			endcase
			case (setup_src)
			csm_pkg::CSM_SRC_DIGITAL: active_setup <= term_setup; // R05
			csm_pkg::CSM_SRC_SERIAL:  active_setup <= bus_setup; // R05
			csm_pkg::CSM_SRC_AND:     active_setup <= term_setup & bus_setup; // R06
			csm_pkg::CSM_SRC_OR:      active_setup <= term_setup | bus_setup; // R07
			default:                  active_setup <= term_setup;
			endcase
			// Bus preset bits count as zero unless the native profile is chosen
			case (pres_src)
			csm_pkg::CSM_SRC_DIGITAL: preset_sel <= term_preset;
			csm_pkg::CSM_SRC_SERIAL:  preset_sel <= bus_preset & {2{native_prof}}; // R08
			csm_pkg::CSM_SRC_AND:     preset_sel <= term_preset & bus_preset & {2{native_prof}}; // R08
			csm_pkg::CSM_SRC_OR:      preset_sel <= term_preset | (bus_preset & {2{native_prof}}); // R08
			default:                  preset_sel <= term_preset;
			endcase
			jog_active <= !native_prof && (bus_jog1_req || bus_jog2_req); // R09
			jog_freq   <= native_prof ? '0 : bus_jog1_req ? jog1_reg : bus_jog2_req ? jog2_reg : '0; // R09
			timeout_reaction <= comm_lost ? ctrl_reg[`CSM_CTRL_REACT_LSB +: 3] : 3'h0; // R13
			relay_on <= !(comm_lost && ctrl_reg[`CSM_CTRL_REACT_LSB +: 3] != 3'h0); // R14
		end
	end

	// Interrupts: bit0 link lost, bit1 link restored; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 2'h0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_fire && awaddr_reg == `CSM_ADDR_IRQ_STAT)
				? wdata_reg[1:0] : 2'h0)) | {restore_event, lost_event};
			irq          <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read channel
	always_comb begin
		rd_err  = 1'b0;
		case (s_axi_araddr)
		`CSM_ADDR_CTRL:     rd_next = ctrl_reg;
		`CSM_ADDR_TIMEOUT:  rd_next = {25'h0, timeout_reg};
		`CSM_ADDR_JOG1:     rd_next = 32'(jog1_reg);
		`CSM_ADDR_JOG2:     rd_next = 32'(jog2_reg);
		`CSM_ADDR_FMAX:     rd_next = 32'(fmax_reg);
		`CSM_ADDR_STATUS:   rd_next = {21'h0, sec_cnt_reg, relay_on, dir_ccw, active_setup[0], comm_lost};
		`CSM_ADDR_IRQ_STAT: rd_next = {30'h0, irq_stat_reg};
		`CSM_ADDR_IRQ_MASK: rd_next = {30'h0, irq_mask_reg};
		default: begin
			rd_next = 32'h0000_0000;
			rd_err  = 1'b1;
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CSM_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_next;
				s_axi_rresp  <= rd_err ? `CSM_RESP_SLVERR : `CSM_RESP_OKAY;
			end else if (s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	AST_DIR_AND: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_src == csm_pkg::CSM_SRC_AND && $stable(dir_src) |=> dir_ccw == ($past(term_reverse) & $past(bus_reverse)))
		else $error("AND direction wrong"); // R03
	AST_DIR_OR: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_src == csm_pkg::CSM_SRC_OR |=> dir_ccw == ($past(term_reverse) | $past(bus_reverse)))
		else $error("OR direction wrong"); // R04
	AST_DIR_DIG: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_src == csm_pkg::CSM_SRC_DIGITAL |=> dir_ccw == $past(term_reverse))
		else $error("Digital direction wrong"); // R01
	AST_DIR_SER: assert property (@(posedge aclk) disable iff (!aresetn)
		dir_src == csm_pkg::CSM_SRC_SERIAL |=> dir_ccw == $past(bus_reverse))
		else $error("Serial direction wrong"); // R02
	AST_SETUP_AND: assert property (@(posedge aclk) disable iff (!aresetn)
		setup_src == csm_pkg::CSM_SRC_AND |=> active_setup == ($past(term_setup) & $past(bus_setup)))
		else $error("AND setup wrong"); // R06
	AST_SETUP_OR: assert property (@(posedge aclk) disable iff (!aresetn)
		setup_src == csm_pkg::CSM_SRC_OR |=> active_setup == ($past(term_setup) | $past(bus_setup)))
		else $error("OR setup wrong"); // R07
	AST_SETUP_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		setup_src == csm_pkg::CSM_SRC_SERIAL |=> active_setup == $past(bus_setup))
		else $error("Serial setup wrong"); // R05
	AST_PRESET_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		pres_src == csm_pkg::CSM_SRC_SERIAL && !native_prof |=> preset_sel == 2'h0)
		else $error("Bus preset honoured in Profidrive"); // R08
	AST_JOG_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		native_prof |=> !jog_active)
		else $error("Bus jog active in native profile"); // R09
	// Checked at the write: lowering the limit later does not clamp a stored jog speed
	AST_JOG_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && awaddr_reg == `CSM_ADDR_JOG1 && wdata_reg[FREQ_W-1:0] > fmax_reg
		|=> $stable(jog1_reg))
		else $error("Jog speed above limit accepted"); // R10
	AST_TIMEOUT_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_reg >= `CSM_TIMEOUT_MIN && timeout_reg <= `CSM_TIMEOUT_MAX)
		else $error("Interval out of range"); // R12
	AST_LOST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
		telegram_ok |=> !comm_lost && sec_cnt_reg == 7'h00)
		else $error("Telegram did not restart timer"); // R15
	AST_LOST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		lost_event |=> comm_lost ##1 (timeout_reaction == $past(ctrl_reg[10:8]) || $past(telegram_ok)))
		else $error("Loss not flagged"); // R13
	AST_RELAY: assert property (@(posedge aclk) disable iff (!aresetn)
		comm_lost && ctrl_reg[10:8] != 3'h0 |=> !relay_on)
		else $error("Relay kept on after timeout"); // R14
endmodule // csm_merge

// ===== csm_master_model.sv
`timescale 1ns/1ns
module csm_master_model #(
	parameter int PERIOD = 10
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic en,
	output logic      telegram_ok
);
	int cnt_reg;
	// Period stays below the shortest limit, so the link never drops while enabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			cnt_reg     <= 0;
			telegram_ok <= 1'h0;
		end else begin
			cnt_reg     <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
			telegram_ok <= (cnt_reg == PERIOD - 1);
		end
	end
endmodule // csm_master_model

// ===== csm_merge_tb.sv
`timescale 1ns/1ns
`include "csm_consts.svh"
module csm_merge_tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, en, tok, dir_ccw, jog_active;
	logic        term_reverse, bus_reverse, jog1, jog2, comm_lost, relay_on, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r, term_setup, bus_setup, term_preset, bus_preset;
	logic [1:0]  active_setup, preset_sel;
	logic [15:0] jog_freq;
	logic [2:0]  timeout_reaction;
	int          mismatches, samples_checked, n;

	csm_merge #(.TICK_CYCLES(20), .FREQ_W(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.term_reverse(term_reverse), .term_setup(term_setup), .term_preset(term_preset),
		.bus_reverse(bus_reverse), .bus_setup(bus_setup), .bus_preset(bus_preset),
		.bus_jog1_req(jog1), .bus_jog2_req(jog2), .telegram_ok(tok), .dir_ccw(dir_ccw),
		.active_setup(active_setup), .preset_sel(preset_sel), .jog_active(jog_active),
		.jog_freq(jog_freq), .comm_lost(comm_lost), .timeout_reaction(timeout_reaction),
		.relay_on(relay_on), .irq(irq));
	csm_master_model #(.PERIOD(10)) master_u (.aclk(aclk), .aresetn(aresetn), .en(en),
		.telegram_ok(tok));

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		mismatches++;
		$display("[FAIL] %0t wait ran out", $time);
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		r = bresp;
		if (k == 100) tmo();
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		d = rdata;
		r = rresp;
		if (k == 100) tmo();
	endtask
	task automatic settle();
		repeat (3) @(posedge aclk);
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] di, su, pr, input logic pf,
		input logic [2:0] re);
		return {21'h0, re, 1'h0, pf, pr, su, di};
	endfunction
	// Same table for direction (one bit) and setup (two bits)
	function automatic logic [1:0] mrg(input int s, input logic [1:0] t, b);
		case (s)
			0: return t;
			1: return b;
			2: return t & b;
			default: return t | b;
		endcase
	endfunction

	initial begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, jog1, jog2} = '0;
		{term_reverse, bus_reverse, term_setup, bus_setup, term_preset, bus_preset} = '0;
		awaddr = '0; araddr = '0; wdata = '0; en = 1'h1;
		mismatches = 0; samples_checked = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`CSM_ADDR_CTRL);
		chk(d, `CSM_CTRL_RESET);
		rd(`CSM_ADDR_TIMEOUT);
		chk(d, 32'(`CSM_TIMEOUT_RESET));
		rd(8'h40);
		chk(r, `CSM_RESP_SLVERR);
		wr(`CSM_ADDR_STATUS, 32'h0000_0000);
		chk(r, `CSM_RESP_SLVERR);
		wr(`CSM_ADDR_IRQ_MASK, 32'h0000_0000);
		chk(r, `CSM_RESP_OKAY);
		chk(relay_on, 32'h1);
		$display("reset test done");
		for (int s = 0; s < 4; s++) begin
			wr(`CSM_ADDR_CTRL, ctl(s[1:0], s[1:0], 2'h3, 1'h1, 3'h0));
			for (int v = 0; v < 16; v++) begin
				@(posedge aclk);
				term_reverse <= v[0];
				bus_reverse  <= v[1];
				term_setup   <= v[1:0];
				bus_setup    <= v[3:2];
				settle();
				chk(dir_ccw, mrg(s, {1'h0, v[0]}, {1'h0, v[1]}));
				chk(active_setup, mrg(s, v[1:0], v[3:2]));
			end
		end
		$display("source merge test done");
		wr(`CSM_ADDR_FMAX, 32'h0000_012C);
		wr(`CSM_ADDR_JOG1, 32'h0000_0064);
		wr(`CSM_ADDR_JOG2, 32'h0000_00C8);
		wr(`CSM_ADDR_JOG1, 32'h0000_0190);
		rd(`CSM_ADDR_JOG1);
		chk(d, 32'h0000_0064);
		for (int pf = 0; pf < 2; pf++) begin
			wr(`CSM_ADDR_CTRL, ctl(2'h3, 2'h3, 2'h1, pf[0], 3'h0));
			@(posedge aclk);
			bus_preset  <= 2'h2;
			term_preset <= 2'h1;
			jog1        <= 1'h1;
			settle();
			chk(preset_sel, pf ? 32'h2 : 32'h0);
			chk(jog_active, pf ? 32'h0 : 32'h1);
			chk(jog_freq, pf ? 32'h0 : 32'h0000_0064);
			@(posedge aclk);
			jog1 <= 1'h0;
			jog2 <= 1'h1;
			settle();
			chk(jog_freq, pf ? 32'h0 : 32'h0000_00C8);
			jog2 <= 1'h0;
		end
		$display("profile test done");
		wr(`CSM_ADDR_TIMEOUT, 32'h0000_0064);
		rd(`CSM_ADDR_TIMEOUT);
		chk(d, 32'h1);
		wr(`CSM_ADDR_TIMEOUT, 32'h2);
		wr(`CSM_ADDR_IRQ_MASK, 32'h1);
		for (int re = 0; re < 6; re++) begin
			wr(`CSM_ADDR_CTRL, ctl(2'h3, 2'h3, 2'h3, 1'h1, re[2:0]));
			chk(comm_lost, 32'h0);
			@(posedge aclk);
			en <= 1'h0;
			for (n = 0; n < 200 && comm_lost !== 1'h1; n++) @(posedge aclk);
			if (n == 200) tmo();
			// Reaction, relay and interrupt are registered one clock behind the loss flag
			@(posedge aclk);
			chk(32'(n >= 33 && n <= 42), 32'h1);
			chk(timeout_reaction, re);
			chk(relay_on, re == 0);
			chk(irq, 32'h1);
			rd(`CSM_ADDR_STATUS);
			chk(d[0], 32'h1);
			chk(d[3], re == 0);
			en <= 1'h1;
			repeat (15) @(posedge aclk);
			chk(comm_lost, 32'h0);
			chk(relay_on, 32'h1);
			wr(`CSM_ADDR_IRQ_STAT, 32'h3);
			settle();
			chk(irq, 32'h0);
		end
		wr(`CSM_ADDR_CTRL, ctl(2'h3, 2'h3, 2'h3, 1'h1, 3'h6));
		rd(`CSM_ADDR_CTRL);
		chk(d[10:8], 32'h5);
		$display("watchdog test done");
		close_out();
	end
endmodule // csm_merge_tb
